// ===== ecc_secded.sv
`timescale 1ns/100ps
`include "qword_ecc_defines.svh"

// ************************************************************
// Single-error-correct, double-error-detect code for a quadword
// ************************************************************
module ecc_secded (
  input wire logic [`QE_DATA_W-1:0] enc_data,
  output logic [`QE_CHECK_W-1:0] enc_check,
  input wire logic [`QE_DATA_W-1:0] dec_data,
  input wire logic [`QE_CHECK_W-1:0] dec_check,
  output logic [`QE_DATA_W-1:0] corr_data,
  output logic single,
  output logic double
);

  // Position of a data bit in the code word, skipping powers of two
  function automatic logic [6:0] data_pos(input integer idx);
    integer p;
    integer n;
    logic [6:0] r;
    begin
      n = 0;
      r = 7'h00;
      for (p = 3; p < 72; p = p + 1)
      begin
        if ((p & (p - 1)) != 0)
        begin
          if (n == idx)
            r = p[6:0];
          n = n + 1;
        end
      end
      data_pos = r;
    end
  endfunction

  logic [6:0] col [`QE_DATA_W];
  logic [`QE_HAMM_W-1:0] enc_hamm;
  logic [`QE_HAMM_W-1:0] dec_hamm;
  logic [`QE_HAMM_W-1:0] syndrome;
  logic parity_bad;

  // Code word position of each data bit, and single-bit repair
  genvar gi;
  generate
    for (gi = 0; gi < `QE_DATA_W; gi = gi + 1)
    begin : g_bit
      assign col[gi] = data_pos(gi);
      assign corr_data[gi] = dec_data[gi] ^
        (parity_bad && (syndrome == col[gi]));
    end
  endgenerate

  // Hamming bits for the data to encode and the data read back
  always_comb
  begin
    enc_hamm = '0;
    dec_hamm = '0;
    for (int j = 0; j < `QE_HAMM_W; j++)
    begin
      for (int i = 0; i < `QE_DATA_W; i++)
      begin
        enc_hamm[j] = enc_hamm[j] ^ (enc_data[i] & col[i][j]);
        dec_hamm[j] = dec_hamm[j] ^ (dec_data[i] & col[i][j]);
      end
    end
  end

  // Overall parity on top makes the 72-bit word even
  assign enc_check = {(^enc_data) ^ (^enc_hamm), enc_hamm};
  assign syndrome = dec_check[`QE_HAMM_W-1:0] ^ dec_hamm;
  assign parity_bad = (^dec_data) ^ (^dec_check);
  // Odd weight: one bit flipped; even weight with syndrome: two bits
  assign single = parity_bad;
  assign double = !parity_bad && (syndrome != '0);

endmodule // ecc_secded

// ===== mem_model.sv
`timescale 1ns/100ps

// ************************************************************
// Memory devices behind the controller, with stalls and flips
// ************************************************************
module mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  output logic cmd_ready,
  input wire logic [28:0] addr,
  input wire logic [63:0] wdata,
  input wire logic [7:0] wcheck,
  input wire logic [7:0] wmask,
  input wire logic [63:0] flip_d,
  input wire logic [7:0] flip_c,
  output logic rd_valid,
  output logic [63:0] rdata,
  output logic [7:0] rcheck
);
  logic [71:0] store [logic [28:0]];
  logic [71:0] word;
  logic [28:0] rd_addr;
  int wait_cnt;

  // Random stalls, delayed read data, lines scrambled when idle
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_ready <= 1'b0;
      rd_valid <= 1'b0;
      rdata <= 64'h0;
      rcheck <= 8'h0;
      wait_cnt = 0;
    end
    else
    begin
      rd_valid <= 1'b0;
      rdata <= ~rdata;
      rcheck <= ~rcheck;
      cmd_ready <= ($urandom % 3) != 0;
      if (wait_cnt == 1)
      begin
        word = store.exists(rd_addr) ? store[rd_addr] : 72'h0;
        rd_valid <= 1'b1;
        rdata <= word[63:0] ^ flip_d;
        rcheck <= word[71:64] ^ flip_c;
      end
      if (wait_cnt > 0)
        wait_cnt = wait_cnt - 1;
      if (cmd_valid && cmd_ready && cmd_write)
      begin
        word = store.exists(addr) ? store[addr] : 72'h0;
        for (int b = 0; b < 8; b++)
          if (wmask[b])
            word[8*b+:8] = wdata[8*b+:8];
        store[addr] = {wcheck, word[63:0]};
      end
      else if (cmd_valid && cmd_ready)
      begin
        rd_addr = addr;
        wait_cnt = 1 + $urandom % 4;
      end
    end
  end
endmodule // mem_model

// ===== qword_ecc_defines.svh
`ifndef QWORD_ECC_DEFINES_SVH
`define QWORD_ECC_DEFINES_SVH

// ************************************************************
// Widths and constants
// ************************************************************
// Quadword data width in bits
`define QE_DATA_W 64
// Check code width in bits
`define QE_CHECK_W 8
// Bytes in one quadword
`define QE_BYTES 8
// Quadword address width
`define QE_ADDR_W 29
// Hamming bits inside the check code
`define QE_HAMM_W 7
// Bit of the check code holding overall parity
`define QE_OVERALL_BIT 7
// Byte mask of a whole quadword
`define QE_FULL_MASK 8'hff
// Check code sent while codes are off
`define QE_NO_CHECK 8'h00

`endif

// ===== qword_ecc_pkg.sv
package qword_ecc_pkg;

  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD = 2'b01,
    ST_READ = 2'b10,
    ST_MERGE = 2'b11
  } seq_state_t;

endpackage

// ===== qword_ecc_read_merge_write.sv
`timescale 1ns/100ps
`include "qword_ecc_defines.svh"

// Operation
// - Codes are generated and checked only while ECC mode is enabled.
// - Each 64-bit quadword gets one 8-bit check code stored beside it.
// - With ECC on, every memory write is a full quadword plus code.
// - Partial writes with ECC on become read-merge-write cycles.
// - Read quadword, merge new bytes, recode, write whole quadword back.
// - Single-bit error in the merge read is corrected before merging.
// - Checked reads correct single-bit errors and flag two-bit errors.
module qword_ecc_read_merge_write (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic ECC_ENABLE,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [`QE_ADDR_W-1:0] REQ_ADDR,
  input wire logic [`QE_DATA_W-1:0] REQ_WDATA,
  input wire logic [`QE_BYTES-1:0] REQ_BE,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [`QE_DATA_W-1:0] RSP_RDATA,
  output logic RSP_UNCORR,
  output logic MEM_CMD_VALID,
  output logic MEM_CMD_WRITE,
  input wire logic MEM_CMD_READY,
  output logic [`QE_ADDR_W-1:0] MEM_ADDR,
  output logic [`QE_DATA_W-1:0] MEM_WDATA,
  output logic [`QE_CHECK_W-1:0] MEM_WCHECK,
  output logic [`QE_BYTES-1:0] MEM_WMASK,
  input wire logic MEM_RD_VALID,
  input wire logic [`QE_DATA_W-1:0] MEM_RDATA,
  input wire logic [`QE_CHECK_W-1:0] MEM_RCHECK,
  output logic CORR_EVENT,
  output logic UNCORR_EVENT
);

  // ************************************************************
  // Datapath
  // ************************************************************
  qword_ecc_pkg::seq_state_t state;
  logic ecc_on;
  logic rmw;
  logic [`QE_DATA_W-1:0] wdata;
  logic [`QE_BYTES-1:0] be;
  logic [`QE_DATA_W-1:0] merged;
  logic [`QE_DATA_W-1:0] merged_c;
  logic [`QE_DATA_W-1:0] be_bits;
  logic [`QE_DATA_W-1:0] enc_data;
  logic [`QE_CHECK_W-1:0] enc_check;
  logic [`QE_DATA_W-1:0] corr_data;
  logic [`QE_DATA_W-1:0] fixed;
  logic single;
  logic double;
  logic rd_done;
  logic partial;

  // Encoder sees the request in idle and the merged word otherwise
  assign enc_data = (state == qword_ecc_pkg::ST_IDLE) ? REQ_WDATA : merged;
  assign fixed = ecc_on ? corr_data : MEM_RDATA;
  assign rd_done = (state == qword_ecc_pkg::ST_READ) && MEM_RD_VALID;
  assign partial = REQ_WRITE && ECC_ENABLE && (REQ_BE != `QE_FULL_MASK);

  ecc_secded u_code (
    .enc_data(enc_data),
    .enc_check(enc_check),
    .dec_data(MEM_RDATA),
    .dec_check(MEM_RCHECK),
    .corr_data(corr_data),
    .single(single),
    .double(double)
  );

  // New bytes replace the corrected old ones byte by byte
  genvar gb;
  generate
    for (gb = 0; gb < `QE_BYTES; gb = gb + 1)
    begin : g_byte
      assign be_bits[gb*8 +: 8] = {8{be[gb]}};
      assign merged_c[gb*8 +: 8] = be[gb] ? wdata[gb*8 +: 8] :
        fixed[gb*8 +: 8];
    end
  endgenerate

  // ************************************************************
  // Sequencer and memory command
  // ************************************************************
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state <= qword_ecc_pkg::ST_IDLE;
      REQ_READY <= 1'b0;
      MEM_CMD_VALID <= 1'b0;
      MEM_CMD_WRITE <= 1'b0;
      MEM_ADDR <= '0;
      MEM_WDATA <= '0;
      MEM_WCHECK <= `QE_NO_CHECK;
      MEM_WMASK <= '0;
      ecc_on <= 1'b0;
      rmw <= 1'b0;
      wdata <= '0;
      be <= '0;
      merged <= '0;
    end
    else
    begin
      case (state)
        qword_ecc_pkg::ST_IDLE:
        begin
          REQ_READY <= 1'b1;
          if (REQ_VALID && REQ_READY)
          begin
            REQ_READY <= 1'b0;
            ecc_on <= ECC_ENABLE;
            MEM_ADDR <= REQ_ADDR;
            wdata <= REQ_WDATA;
            be <= REQ_BE;
            rmw <= partial;
            MEM_CMD_VALID <= 1'b1;
            MEM_CMD_WRITE <= REQ_WRITE && !partial;
            MEM_WDATA <= REQ_WDATA;
            // Full write: code travels with the data
            MEM_WCHECK <= ECC_ENABLE ? enc_check : `QE_NO_CHECK;
            MEM_WMASK <= ECC_ENABLE ? `QE_FULL_MASK : REQ_BE;
            state <= qword_ecc_pkg::ST_CMD;
          end
        end
        qword_ecc_pkg::ST_CMD:
        begin
          if (MEM_CMD_READY)
          begin
            MEM_CMD_VALID <= 1'b0;
            if (MEM_CMD_WRITE)
            begin
              REQ_READY <= 1'b1;
              state <= qword_ecc_pkg::ST_IDLE;
            end
            else
              state <= qword_ecc_pkg::ST_READ;
          end
        end
        qword_ecc_pkg::ST_READ:
        begin
          if (MEM_RD_VALID)
          begin
            // Uncorrectable old data is not written back
            if (rmw && !double)
            begin
              merged <= merged_c;
              state <= qword_ecc_pkg::ST_MERGE;
            end
            else
            begin
              REQ_READY <= 1'b1;
              state <= qword_ecc_pkg::ST_IDLE;
            end
          end
        end
        qword_ecc_pkg::ST_MERGE:
        begin
          // Whole merged quadword goes back with a fresh code
          MEM_CMD_VALID <= 1'b1;
          MEM_CMD_WRITE <= 1'b1;
          MEM_WDATA <= merged;
          MEM_WCHECK <= enc_check;
          MEM_WMASK <= `QE_FULL_MASK;
          state <= qword_ecc_pkg::ST_CMD;
        end
        default:
          state <= qword_ecc_pkg::ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Read response
  // ************************************************************
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      RSP_VALID <= 1'b0;
      RSP_RDATA <= '0;
      RSP_UNCORR <= 1'b0;
    end
    else
    begin
      RSP_VALID <= rd_done && !rmw;
      if (rd_done && !rmw)
      begin
        RSP_RDATA <= fixed;
        RSP_UNCORR <= ecc_on && double;
      end
    end
  end

  // ************************************************************
  // Error event pulses
  // ************************************************************
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      CORR_EVENT <= 1'b0;
      UNCORR_EVENT <= 1'b0;
    end
    else
    begin
      CORR_EVENT <= rd_done && ecc_on && single;
      UNCORR_EVENT <= rd_done && ecc_on && double;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence rmw_read_s;
    rd_done && rmw && !double;
  endsequence

  sequence rmw_write_s;
    (state == qword_ecc_pkg::ST_MERGE) ##1
      (MEM_CMD_VALID && MEM_CMD_WRITE && MEM_WMASK == `QE_FULL_MASK);
  endsequence

  no_code_off_a: assert property (
    MEM_CMD_VALID && MEM_CMD_WRITE && !ecc_on |->
      MEM_WCHECK == `QE_NO_CHECK)
    else $error("Check code sent with ECC off");

  code_stored_a: assert property (
    (state == qword_ecc_pkg::ST_MERGE) |=> MEM_WCHECK == $past(enc_check))
    else $error("Merged write carries wrong check code");

  full_write_a: assert property (
    MEM_CMD_VALID && MEM_CMD_WRITE && ecc_on |->
      MEM_WMASK == `QE_FULL_MASK)
    else $error("Partial memory write with ECC on");

  rmw_start_a: assert property (
    (state == qword_ecc_pkg::ST_IDLE) && REQ_VALID && REQ_READY && partial
      |=> MEM_CMD_VALID && !MEM_CMD_WRITE && rmw)
    else $error("Partial write did not start with a read");

  rmw_order_a: assert property (
    rmw_read_s |=> rmw_write_s ##0 (MEM_WDATA == $past(merged, 1)))
    else $error("Read-merge-write sequence broken");

  merge_fixed_a: assert property (
    rmw_read_s |=> ((merged ^ $past(corr_data)) & ~be_bits) == '0)
    else $error("Old bytes not corrected before merge");

  read_check_a: assert property (
    rd_done && !rmw && ecc_on |=> RSP_VALID &&
      RSP_RDATA == $past(corr_data) && RSP_UNCORR == $past(double))
    else $error("Checked read answer wrong");

  err_flags_a: assert property (
    rd_done && ecc_on |=> CORR_EVENT == $past(single) &&
      UNCORR_EVENT == $past(double))
    else $error("Error event pulse wrong");

endmodule // qword_ecc_read_merge_write

// ===== qword_ecc_read_merge_write_bench.sv
`timescale 1ns/100ps

// ************************************************************
// Bench: reference memory, code and event model
// ************************************************************
module qword_ecc_read_merge_write_bench;
  logic CLK = 0, RESET_N = 0, ECC_ENABLE = 0, REQ_VALID = 0, REQ_WRITE = 0;
  logic [28:0] REQ_ADDR = 0, MEM_ADDR, exp_a;
  logic [63:0] REQ_WDATA = 0, RSP_RDATA, MEM_WDATA, MEM_RDATA, exp_wd;
  logic [7:0] REQ_BE = 0, MEM_WCHECK, MEM_WMASK, MEM_RCHECK, exp_wc, exp_wm;
  logic REQ_READY, RSP_VALID, RSP_UNCORR, MEM_CMD_VALID, MEM_CMD_WRITE;
  logic MEM_CMD_READY, MEM_RD_VALID, CORR_EVENT, UNCORR_EVENT;
  logic [63:0] flip_d = 0, ref_mem [logic [28:0]];
  logic [7:0] flip_c = 0;
  int error_cnt = 0, checked = 0, corr_cnt = 0, uncorr_cnt = 0;
  int wr_cnt = 0, rd_cnt = 0;

  qword_ecc_read_merge_write dut_u (.CLK(CLK), .RESET_N(RESET_N),
    .ECC_ENABLE(ECC_ENABLE), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
    .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_BE(REQ_BE),
    .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
    .RSP_UNCORR(RSP_UNCORR), .MEM_CMD_VALID(MEM_CMD_VALID),
    .MEM_CMD_WRITE(MEM_CMD_WRITE), .MEM_CMD_READY(MEM_CMD_READY),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_WCHECK(MEM_WCHECK),
    .MEM_WMASK(MEM_WMASK), .MEM_RD_VALID(MEM_RD_VALID),
    .MEM_RDATA(MEM_RDATA), .MEM_RCHECK(MEM_RCHECK),
    .CORR_EVENT(CORR_EVENT), .UNCORR_EVENT(UNCORR_EVENT));

  mem_model mem_u (.clk(CLK), .rst_n(RESET_N), .cmd_valid(MEM_CMD_VALID),
    .cmd_write(MEM_CMD_WRITE), .cmd_ready(MEM_CMD_READY), .addr(MEM_ADDR),
    .wdata(MEM_WDATA), .wcheck(MEM_WCHECK), .wmask(MEM_WMASK),
    .flip_d(flip_d), .flip_c(flip_c), .rd_valid(MEM_RD_VALID),
    .rdata(MEM_RDATA), .rcheck(MEM_RCHECK));

  // Free-running clock
  always #5 CLK = ~CLK;

  // Extended Hamming code worked out bit by bit
  function automatic logic [7:0] code_of(input logic [63:0] d);
    logic [7:0] c;
    int pos;
    c = 8'h00;
    pos = 3;
    for (int i = 0; i < 64; i++)
    begin
      while ((pos & (pos - 1)) == 0)
        pos++;
      for (int k = 0; k < 7; k++)
        if (pos[k])
          c[k] = c[k] ^ d[i];
      pos++;
    end
    c[7] = ^{d, c[6:0]};
    return c;
  endfunction

  // Byte mask widened to a bit mask
  function automatic logic [63:0] wide(input logic [7:0] m);
    for (int b = 0; b < 8; b++)
      wide[8*b+:8] = {8{m[b]}};
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Error pulses counted mid-cycle, clear of the edge the task wakes on
  always @(negedge CLK)
  begin
    corr_cnt += (CORR_EVENT === 1'b1);
    uncorr_cnt += (UNCORR_EVENT === 1'b1);
  end

  // Memory commands seen at the ports
  always @(posedge CLK)
  begin
    if (MEM_CMD_VALID === 1'b1 && MEM_CMD_READY === 1'b1)
    begin
      chk(64'(MEM_ADDR), 64'(exp_a));
      if (MEM_CMD_WRITE === 1'b1)
      begin
        wr_cnt++;
        chk(MEM_WDATA & wide(exp_wm), exp_wd & wide(exp_wm));
        chk(64'(MEM_WCHECK), 64'(exp_wc));
        chk(64'(MEM_WMASK), 64'(exp_wm));
      end
      else
        rd_cnt++;
    end
  end

  // One request through the design, checked against the model
  task automatic op(input logic wr, input logic [28:0] a,
      input logic [63:0] d, input logic [7:0] be, input logic ecc,
      input logic [63:0] fd, input logic [7:0] fc);
    logic [63:0] old, got;
    logic gotu, rmw, dbl;
    int c0, u0, w0, r0, n;
    old = ref_mem.exists(a) ? ref_mem[a] : 64'h0;
    rmw = !wr || (ecc && be != 8'hff);
    dbl = ecc && rmw && $countones({fd, fc}) == 2;
    {c0, u0, w0, r0} = {corr_cnt, uncorr_cnt, wr_cnt, rd_cnt};
    n = 0;
    {got, gotu, exp_a, exp_wm} = {65'bx, a, ecc ? 8'hff : be};
    exp_wd = (old & ~wide(be)) | (d & wide(be));
    exp_wc = ecc ? code_of(exp_wd) : 8'h00;
    {flip_d, flip_c, ECC_ENABLE, REQ_VALID, REQ_WRITE} <= {fd, fc, ecc, 1'b1, wr};
    {REQ_ADDR, REQ_WDATA, REQ_BE} <= {a, d, be};
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (REQ_READY !== 1'b1 && n < 500);
    REQ_VALID <= 1'b0;
    do
    begin
      @(posedge CLK);
      n++;
      if (RSP_VALID === 1'b1)
        {got, gotu} = {RSP_RDATA, RSP_UNCORR};
    end
    while (REQ_READY !== 1'b1 && n < 500);
    if (n >= 500)
    begin
      error_cnt++;
      end_of_test();
    end
    chk(64'(rd_cnt - r0), 64'(rmw));
    chk(64'(corr_cnt - c0), 64'(ecc && rmw && !dbl && (fd | fc) != 0));
    chk(64'(uncorr_cnt - u0), 64'(dbl));
    chk(64'(wr_cnt - w0), 64'(wr && !dbl));
    if (!wr)
      chk(64'(gotu), 64'(dbl));
    if (!wr && !dbl)
      chk(got, ecc ? old : old ^ fd);
    if (wr && !dbl)
      ref_mem[a] = exp_wd;
  endtask

  // Reset, then random rounds over every kind of access
  initial
  begin
    logic [28:0] a;
    logic [63:0] d, d2, bi;
    logic [7:0] be, bj;
    void'($urandom(32'h11daecd1));
    repeat (6) @(posedge CLK);
    RESET_N <= 1'b1;
    for (int r = 0; r < 6; r++)
    begin
      a = 29'($urandom % 4);
      {d, d2, bi, bj} = {$urandom, $urandom, $urandom, $urandom,
        64'h1 << ($urandom % 64), 8'h1 << ($urandom % 8)};
      be = 8'($urandom % 254 + 1);
      op(1, a, d, 8'hff, 1, 0, 0);
      op(0, a, 0, 0, 1, 0, 0);
      op(0, a, 0, 0, 1, bi, 0);
      op(0, a, 0, 0, 1, 0, bj);
      op(0, a, 0, 0, 1, bi, bj);
      op(1, a, d2, be, 1, bi, 0);
      op(1, a, d, ~be, 1, 0, 0);
      op(1, a, d2, be, 1, bi, bj);
      op(0, a, 0, 0, 1, 0, 0);
      op(1, a + 8, d, 8'hff, 0, 0, 0);
      op(1, a + 8, d2, be, 0, bi, 0);
      op(0, a + 8, 0, 0, 0, bi, bj);
    end
    end_of_test();
  end
endmodule // qword_ecc_read_merge_write_bench
